// file: hdl/mixout_pkg.sv
// shared constants and types for the stereo mix and output-stage control
package mixout_pkg;

    // control word layout
    localparam int CTRL_W      = 64;
    localparam int MIX_LSB     = 46;
    localparam int MIX_MSB     = 49;
    localparam int HBON_BIT    = 50;
    localparam int PCOMP_LSB   = 51;
    localparam int PCOMP_MSB   = 55;
    localparam int NCOMP_LSB   = 56;
    localparam int NCOMP_MSB   = 60;
    localparam int ALP_BIT     = 61;
    localparam int SPEED_BIT   = 62;
    localparam int METHOD_BIT  = 63;

    // field widths
    localparam int MIX_W       = 4;
    localparam int COMP_W      = 5;

    // reset values
    localparam logic [3:0] MIX_RST    = 4'h9;
    localparam logic       HBON_RST   = 1'h0;
    localparam logic [4:0] PCOMP_RST  = 5'h10;
    localparam logic [4:0] NCOMP_RST  = 5'h00;
    localparam logic       ALP_RST    = 1'h0;
    localparam logic       SPEED_RST  = 1'h0;
    localparam logic       METHOD_RST = 1'h0;

    // audio path
    localparam int SAMPLE_W    = 24;
    localparam int PAIR_W      = 2 * SAMPLE_W;

    // source choice for one output channel
    typedef enum logic [1:0] {
        SRC_MUTE  = 2'h0,
        SRC_RIGHT = 2'h1,
        SRC_LEFT  = 2'h2,
        SRC_MEAN  = 2'h3
    } mix_src_t;

    // output switching mode, one-hot
    typedef enum logic [3:0] {
        MODE_R500 = 4'h1,
        MODE_H1M  = 4'h2,
        MODE_R1M  = 4'h4,
        MODE_H2M  = 4'h8
    } sw_mode_t;

    // switching rates and the clock, in kHz
    localparam int CLK_KHZ     = 125000;
    localparam int PWM_LO_KHZ  = 500;
    localparam int PWM_MID_KHZ = 1000;
    localparam int PWM_HI_KHZ  = 2000;

    // carrier periods in clock cycles, rounded down
    localparam int DIV_LO      = CLK_KHZ / PWM_LO_KHZ;
    localparam int DIV_MID     = CLK_KHZ / PWM_MID_KHZ;
    localparam int DIV_HI      = CLK_KHZ / PWM_HI_KHZ;
    localparam int DIV_W       = 8;

    // digital silence detection
    localparam int SIL_W       = 11;
    localparam int SIL_DEFAULT = 1024;

endpackage

// file: hdl/mix_skid_buf.sv
// two-entry skid buffer carrying mixed stereo pairs
`timescale 1ns/1ps
`default_nettype none

module mix_skid_buf (
    // clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_i,
    // filling side
    input  wire logic                          in_valid_i,
    input  wire logic [mixout_pkg::PAIR_W-1:0] in_data_i,
    output logic                               in_ready_o,
    // draining side
    output logic                               out_valid_o,
    output logic [mixout_pkg::PAIR_W-1:0]      out_data_o,
    input  wire logic                          out_ready_i
);

    typedef struct packed {
        logic [mixout_pkg::PAIR_W-1:0] out_data;
        logic                          out_valid;
        logic [mixout_pkg::PAIR_W-1:0] skid_data;
        logic                          skid_valid;
    } buf_state_t;

    buf_state_t st_q;
    buf_state_t st_d;
    logic       push;
    logic       pop;

    // ready is a flop: the skid entry absorbs the word taken while stalling
    assign push = in_valid_i && !st_q.skid_valid;
    assign pop  = st_q.out_valid && out_ready_i;

    always_comb begin
        st_d = st_q;
        if (!st_q.out_valid || pop) begin
            if (st_q.skid_valid) begin
                st_d.out_data   = st_q.skid_data;
                st_d.out_valid  = 1'b1;
                st_d.skid_valid = 1'b0;
            end else if (push) begin
                st_d.out_data  = in_data_i;
                st_d.out_valid = 1'b1;
            end else begin
                st_d.out_valid = 1'b0;
            end
        end else if (push) begin
            st_d.skid_data  = in_data_i;
            st_d.skid_valid = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign in_ready_o  = !st_q.skid_valid;
    assign out_valid_o = st_q.out_valid;
    assign out_data_o  = st_q.out_data;

    a_out_hold_stall: assert property (@(posedge clk_i) disable iff (rst_i)
        out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
        else $error("buffer output changed while stalled");

    a_full_refuses: assert property (@(posedge clk_i) disable iff (rst_i)
        st_q.skid_valid |-> st_q.out_valid && !in_ready_o)
        else $error("buffer full but still ready");

endmodule

`default_nettype wire

// file: hdl/stereo_mix_output_mode_ctrl.sv
// stereo channel mixer and output-stage configuration from the control word
//
// Overview of operation
// - the four-bit mix code is taken from control word bits 46 to 49, bit 46 lowest.
// - the upper two mix bits pick the left output: mute, right, left or the mean.
// - the lower two mix bits pick the right output: mute, right, left or the mean.
// - after reset the mix code is 1001, left to left and right to right.
// - control word bit 50 turns the H-bridge drive on when one and off when zero.
// - after reset the bridge drive is off until the host sets it.
// - control word bit 61 enables auto low power; only then may silence be flagged.
// - control word bit 62 selects low speed when zero and high speed when one.
// - speed and method set the mode: 500kHz, 1MHz enhanced, 1MHz regular, 2MHz.
`timescale 1ns/1ps
`default_nettype none

module stereo_mix_output_mode_ctrl #(
    parameter int SILENCE_SAMPLES = mixout_pkg::SIL_DEFAULT
) (
    // clock and reset
    input  wire logic                            CLK_I,
    input  wire logic                            RST_I,
    // control word from the serial interface logic
    input  wire logic [mixout_pkg::CTRL_W-1:0]   CTRL_WORD_I,
    input  wire logic                            CTRL_LOAD_I,
    // stereo input samples
    input  wire logic                            IN_VALID_I,
    input  wire logic [mixout_pkg::SAMPLE_W-1:0] IN_LEFT_I,
    input  wire logic [mixout_pkg::SAMPLE_W-1:0] IN_RIGHT_I,
    output logic                                 IN_READY_O,
    // mixed output samples
    output logic                                 OUT_VALID_O,
    output logic [mixout_pkg::SAMPLE_W-1:0]      OUT_LEFT_O,
    output logic [mixout_pkg::SAMPLE_W-1:0]      OUT_RIGHT_O,
    input  wire logic                            OUT_READY_I,
    // output stage configuration
    output logic [mixout_pkg::MIX_W-1:0]         MIX_CODE_O,
    output logic                                 HBRIDGE_EN_O,
    output logic [mixout_pkg::COMP_W-1:0]        PCOMP_O,
    output logic [mixout_pkg::COMP_W-1:0]        NCOMP_O,
    output logic                                 AUTO_LOW_POWER_O,
    output logic                                 SPEED_HIGH_O,
    output logic                                 METHOD_ENH_O,
    output logic [3:0]                           SW_MODE_O,
    output logic                                 PWM_TICK_O,
    output logic                                 SILENT_O
);

    localparam int SW = mixout_pkg::SAMPLE_W;

    typedef struct packed {
        logic [mixout_pkg::MIX_W-1:0]  mix;
        logic                          hbon;
        logic [mixout_pkg::COMP_W-1:0] pcomp;
        logic [mixout_pkg::COMP_W-1:0] ncomp;
        logic                          alp;
        logic                          speed;
        logic                          method;
        mixout_pkg::sw_mode_t          mode;
        logic [mixout_pkg::DIV_W-1:0]  div_cnt;
        logic                          tick;
        logic [mixout_pkg::SIL_W-1:0]  sil_cnt;
        logic                          silent;
    } ctrl_state_t;

    ctrl_state_t st_q;
    ctrl_state_t st_d;

    logic [SW-1:0]                 mix_left;
    logic [SW-1:0]                 mix_right;
    logic [SW-1:0]                 mean_val;
    logic                          buf_ready;
    logic                          take;
    logic [mixout_pkg::PAIR_W-1:0] buf_out;
    logic                          in_zero;

    localparam logic [mixout_pkg::SIL_W-1:0] SIL_LIMIT =
        mixout_pkg::SIL_W'(SILENCE_SAMPLES);

    // sign-extend before adding so the full-scale sum cannot wrap
    function automatic logic [SW-1:0] mean_of(
        input logic [SW-1:0] l,
        input logic [SW-1:0] r
    );
        logic [SW:0] sum;
        sum = {l[SW-1], l} + {r[SW-1], r};
        return sum[SW:1];
    endfunction

    function automatic logic [SW-1:0] pick(
        input mixout_pkg::mix_src_t src,
        input logic [SW-1:0]        l,
        input logic [SW-1:0]        r,
        input logic [SW-1:0]        m
    );
        logic [SW-1:0] res;
        res = '0;
        case (src)
            mixout_pkg::SRC_RIGHT: res = r;
            mixout_pkg::SRC_LEFT:  res = l;
            mixout_pkg::SRC_MEAN:  res = m;
            default:               res = '0;
        endcase
        return res;
    endfunction

    function automatic mixout_pkg::sw_mode_t mode_of(
        input logic speed,
        input logic method
    );
        mixout_pkg::sw_mode_t m;
        m = mixout_pkg::MODE_R500;
        if (speed && method) begin
            m = mixout_pkg::MODE_H2M;
        end else if (speed) begin
            m = mixout_pkg::MODE_R1M;
        end else if (method) begin
            m = mixout_pkg::MODE_H1M;
        end
        return m;
    endfunction

    function automatic logic [mixout_pkg::DIV_W-1:0] reload_of(
        input mixout_pkg::sw_mode_t m
    );
        logic [mixout_pkg::DIV_W-1:0] v;
        v = mixout_pkg::DIV_W'(mixout_pkg::DIV_LO - 1);
        case (m)
            mixout_pkg::MODE_H1M: v = mixout_pkg::DIV_W'(mixout_pkg::DIV_MID - 1);
            mixout_pkg::MODE_R1M: v = mixout_pkg::DIV_W'(mixout_pkg::DIV_MID - 1);
            mixout_pkg::MODE_H2M: v = mixout_pkg::DIV_W'(mixout_pkg::DIV_HI - 1);
            default:              v = mixout_pkg::DIV_W'(mixout_pkg::DIV_LO - 1);
        endcase
        return v;
    endfunction

    // mixing is combinational so a new code applies from the next pair
    assign mean_val  = mean_of(IN_LEFT_I, IN_RIGHT_I);
    assign mix_left  = pick(mixout_pkg::mix_src_t'(st_q.mix[3:2]),
                            IN_LEFT_I, IN_RIGHT_I, mean_val);
    assign mix_right = pick(mixout_pkg::mix_src_t'(st_q.mix[1:0]),
                            IN_LEFT_I, IN_RIGHT_I, mean_val);
    assign take      = IN_VALID_I && buf_ready;
    assign in_zero   = (IN_LEFT_I == '0) && (IN_RIGHT_I == '0);

    always_comb begin
        st_d = st_q;
        if (CTRL_LOAD_I) begin
            st_d.mix    = CTRL_WORD_I[mixout_pkg::MIX_MSB:mixout_pkg::MIX_LSB];
            st_d.hbon   = CTRL_WORD_I[mixout_pkg::HBON_BIT];
            // compensation values pass as written; range is the host's duty
            st_d.pcomp  = CTRL_WORD_I[mixout_pkg::PCOMP_MSB:mixout_pkg::PCOMP_LSB];
            st_d.ncomp  = CTRL_WORD_I[mixout_pkg::NCOMP_MSB:mixout_pkg::NCOMP_LSB];
            st_d.alp    = CTRL_WORD_I[mixout_pkg::ALP_BIT];
            st_d.speed  = CTRL_WORD_I[mixout_pkg::SPEED_BIT];
            st_d.method = CTRL_WORD_I[mixout_pkg::METHOD_BIT];
        end
        st_d.mode = mode_of(st_d.speed, st_d.method);

        // carrier divider; a mode change restarts the period without a tick
        st_d.tick = 1'b0;
        if (st_d.mode != st_q.mode) begin
            st_d.div_cnt = reload_of(st_d.mode);
        end else if (st_q.div_cnt == '0) begin
            st_d.div_cnt = reload_of(st_d.mode);
            st_d.tick    = 1'b1;
        end else begin
            st_d.div_cnt = st_q.div_cnt - 1'b1;
        end

        // silence counts zero input pairs and saturates at the limit
        if (!st_q.alp) begin
            st_d.sil_cnt = '0;
            st_d.silent  = 1'b0;
        end else begin
            if (take && !in_zero) begin
                st_d.sil_cnt = '0;
            end else if (take && st_q.sil_cnt != SIL_LIMIT) begin
                st_d.sil_cnt = st_q.sil_cnt + 1'b1;
            end
            st_d.silent = (st_d.sil_cnt == SIL_LIMIT);
        end
    end

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            st_q.mix     <= mixout_pkg::MIX_RST;
            st_q.hbon    <= mixout_pkg::HBON_RST;
            st_q.pcomp   <= mixout_pkg::PCOMP_RST;
            st_q.ncomp   <= mixout_pkg::NCOMP_RST;
            st_q.alp     <= mixout_pkg::ALP_RST;
            st_q.speed   <= mixout_pkg::SPEED_RST;
            st_q.method  <= mixout_pkg::METHOD_RST;
            st_q.mode    <= mixout_pkg::MODE_R500;
            st_q.div_cnt <= '0;
            st_q.tick    <= 1'b0;
            st_q.sil_cnt <= '0;
            st_q.silent  <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    // a stalled receiver back-pressures the source through the buffer
    mix_skid_buf u_buf (
        .clk_i       (CLK_I),
        .rst_i       (RST_I),
        .in_valid_i  (IN_VALID_I),
        .in_data_i   ({mix_left, mix_right}),
        .in_ready_o  (buf_ready),
        .out_valid_o (OUT_VALID_O),
        .out_data_o  (buf_out),
        .out_ready_i (OUT_READY_I)
    );

    assign IN_READY_O       = buf_ready;
    assign OUT_LEFT_O       = buf_out[mixout_pkg::PAIR_W-1:SW];
    assign OUT_RIGHT_O      = buf_out[SW-1:0];
    assign MIX_CODE_O       = st_q.mix;
    assign HBRIDGE_EN_O     = st_q.hbon;
    assign PCOMP_O          = st_q.pcomp;
    assign NCOMP_O          = st_q.ncomp;
    assign AUTO_LOW_POWER_O = st_q.alp;
    assign SPEED_HIGH_O     = st_q.speed;
    assign METHOD_ENH_O     = st_q.method;
    assign SW_MODE_O        = st_q.mode;
    assign PWM_TICK_O       = st_q.tick;
    assign SILENT_O         = st_q.silent;

    a_mix_code_load: assert property (@(posedge CLK_I) disable iff (RST_I)
        CTRL_LOAD_I |=> MIX_CODE_O ==
            $past(CTRL_WORD_I[mixout_pkg::MIX_MSB:mixout_pkg::MIX_LSB]))
        else $error("mix code not taken from the control word");

    a_left_select: assert property (@(posedge CLK_I) disable iff (RST_I)
        take |-> mix_left == (st_q.mix[3:2] == 2'h0 ? '0 :
                              st_q.mix[3:2] == 2'h1 ? IN_RIGHT_I :
                              st_q.mix[3:2] == 2'h2 ? IN_LEFT_I : mean_val))
        else $error("left output source wrong");

    a_right_mean: assert property (@(posedge CLK_I) disable iff (RST_I)
        take && st_q.mix[1:0] == 2'h3 |->
            mix_right == SW'(({IN_LEFT_I[SW-1], IN_LEFT_I}
                              + {IN_RIGHT_I[SW-1], IN_RIGHT_I}) >> 1))
        else $error("right output mean wrong");

    a_mute_zero_out: assert property (@(posedge CLK_I) disable iff (RST_I)
        take && buf_ready && !OUT_VALID_O && st_q.mix[1:0] == 2'h0 |=>
            OUT_VALID_O && OUT_RIGHT_O == '0)
        else $error("muted right channel not zero");

    a_mute_left_zero: assert property (@(posedge CLK_I) disable iff (RST_I)
        take && !OUT_VALID_O && st_q.mix[3:2] == 2'h0 |=>
            OUT_VALID_O && OUT_LEFT_O == '0)
        else $error("muted left channel not zero");

    a_mix_reset_val: assert property (@(posedge CLK_I)
        RST_I |=> MIX_CODE_O == mixout_pkg::MIX_RST)
        else $error("mix code reset value wrong");

    a_bridge_reset_off: assert property (@(posedge CLK_I)
        RST_I |=> !HBRIDGE_EN_O)
        else $error("bridge drive on after reset");

    a_bridge_follows: assert property (@(posedge CLK_I) disable iff (RST_I)
        CTRL_LOAD_I |=> HBRIDGE_EN_O == $past(CTRL_WORD_I[mixout_pkg::HBON_BIT]))
        else $error("bridge drive does not follow bit");

    a_silence_gated: assert property (@(posedge CLK_I) disable iff (RST_I)
        !AUTO_LOW_POWER_O |=> !SILENT_O)
        else $error("silence flagged with auto low power off");

    a_speed_method: assert property (@(posedge CLK_I) disable iff (RST_I)
        CTRL_LOAD_I |=> SPEED_HIGH_O == $past(CTRL_WORD_I[mixout_pkg::SPEED_BIT])
            && METHOD_ENH_O == $past(CTRL_WORD_I[mixout_pkg::METHOD_BIT]))
        else $error("speed or method not taken");

    a_mode_map: assert property (@(posedge CLK_I) disable iff (RST_I)
        SPEED_HIGH_O && !METHOD_ENH_O |-> SW_MODE_O == mixout_pkg::MODE_R1M)
        else $error("switching mode does not match speed and method");

    a_mode_lo_reg: assert property (@(posedge CLK_I) disable iff (RST_I)
        !SPEED_HIGH_O && !METHOD_ENH_O |-> SW_MODE_O == mixout_pkg::MODE_R500)
        else $error("regular low speed mode wrong");

    a_mode_lo_enh: assert property (@(posedge CLK_I) disable iff (RST_I)
        !SPEED_HIGH_O && METHOD_ENH_O |-> SW_MODE_O == mixout_pkg::MODE_H1M)
        else $error("enhanced low speed mode wrong");

    a_mode_hi_enh: assert property (@(posedge CLK_I) disable iff (RST_I)
        SPEED_HIGH_O && METHOD_ENH_O |-> SW_MODE_O == mixout_pkg::MODE_H2M)
        else $error("enhanced high speed mode wrong");

    a_tick_spacing: assert property (@(posedge CLK_I) disable iff (RST_I)
        PWM_TICK_O |=> !PWM_TICK_O [*8])
        else $error("carrier ticks too close together");

endmodule

`default_nettype wire

// file: bench/host_word_model.sv
// host side model that hands whole control words to the mixer
`timescale 1ns/1ps
`default_nettype none

module host_word_model (
    // clock
    input  wire logic        clk_i,
    // control word towards the device
    output logic [63:0]      ctrl_word_o,
    output logic             ctrl_load_o
);
    logic [63:0] last_word;

    initial begin
        ctrl_word_o = 64'h0;
        ctrl_load_o = 1'b0;
        last_word   = 64'h0;
    end

    // one load pulse; the word line is scrambled once it is not qualified
    task automatic send(input logic [63:0] w);
        if (w[60:56] > 5'h08) w[60:56] = 5'h08;
        if (w[55:51] < 5'h08) w[55:51] = 5'h10;
        if (w[55:51] > 5'h10) w[55:51] = 5'h10;
        @(negedge clk_i);
        ctrl_word_o = w;
        ctrl_load_o = 1'b1;
        last_word   = w;
        @(negedge clk_i);
        ctrl_load_o = 1'b0;
        ctrl_word_o = ~w;
    endtask

    // first setting after power up: enhanced method, low speed, bridge off
    task automatic first_use();
        send({2'h2, 1'h0, 5'h00, 5'h10, 1'h0, 4'h9, 46'h0});
    endtask
endmodule

`default_nettype wire

// file: bench/stereo_mix_output_mode_ctrl_tb_top.sv
// self-checking bench for the stereo mixer and output-stage control
`timescale 1ns/1ps
`default_nettype none

module stereo_mix_output_mode_ctrl_tb_top;
    localparam int SIL_N = 4;

    logic        CLK_I, RST_I, CTRL_LOAD_I, IN_VALID_I, IN_READY_O;
    logic        OUT_VALID_O, OUT_READY_I, HBRIDGE_EN_O, AUTO_LOW_POWER_O;
    logic        SPEED_HIGH_O, METHOD_ENH_O, PWM_TICK_O, SILENT_O;
    logic [63:0] CTRL_WORD_I, w;
    logic [23:0] IN_LEFT_I, IN_RIGHT_I, OUT_LEFT_O, OUT_RIGHT_O;
    logic [3:0]  MIX_CODE_O, SW_MODE_O, cur_mix;
    logic [4:0]  PCOMP_O, NCOMP_O;
    logic        hold, jitter;
    logic [47:0] exp_q[$];
    logic [47:0] corner[4] = '{48'h7fffff7fffff, 48'h800000800000,
                               48'h000001000000, 48'hffffff000000};
    int          bad_count, compares, seed, gap;

    host_word_model host_word_model_inst (
        .clk_i       (CLK_I),
        .ctrl_word_o (CTRL_WORD_I),
        .ctrl_load_o (CTRL_LOAD_I)
    );

    stereo_mix_output_mode_ctrl #(.SILENCE_SAMPLES(SIL_N))
        stereo_mix_output_mode_ctrl_inst (
        .CLK_I(CLK_I), .RST_I(RST_I),
        .CTRL_WORD_I(CTRL_WORD_I), .CTRL_LOAD_I(CTRL_LOAD_I),
        .IN_VALID_I(IN_VALID_I), .IN_LEFT_I(IN_LEFT_I),
        .IN_RIGHT_I(IN_RIGHT_I), .IN_READY_O(IN_READY_O),
        .OUT_VALID_O(OUT_VALID_O), .OUT_LEFT_O(OUT_LEFT_O),
        .OUT_RIGHT_O(OUT_RIGHT_O), .OUT_READY_I(OUT_READY_I),
        .MIX_CODE_O(MIX_CODE_O), .HBRIDGE_EN_O(HBRIDGE_EN_O),
        .PCOMP_O(PCOMP_O), .NCOMP_O(NCOMP_O),
        .AUTO_LOW_POWER_O(AUTO_LOW_POWER_O), .SPEED_HIGH_O(SPEED_HIGH_O),
        .METHOD_ENH_O(METHOD_ENH_O), .SW_MODE_O(SW_MODE_O),
        .PWM_TICK_O(PWM_TICK_O), .SILENT_O(SILENT_O)
    );

    initial begin
        CLK_I = 1'b0;
        forever #4 CLK_I = ~CLK_I;
    end

    function automatic logic [23:0] pick(input logic [1:0] s,
                                         input logic [23:0] l,
                                         input logic [23:0] r);
        logic [24:0] sum;
        sum = {l[23], l} + {r[23], r};
        case (s)
            2'h0: pick = 24'h0;
            2'h1: pick = r;
            2'h2: pick = l;
            default: pick = sum[24:1];
        endcase
    endfunction

    task automatic test_done();
        if (bad_count == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [63:0] e,
                       input logic [63:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // receiver: stalls at random so the skid entry gets used
    always @(negedge CLK_I) begin
        OUT_READY_I = hold ? 1'b0 : (jitter ? 1'($random(seed)) : 1'b1);
    end

    // scoreboard: expectation built from the mix code we commanded
    always @(posedge CLK_I) begin
        if (!RST_I && IN_VALID_I && IN_READY_O)
            exp_q.push_back({pick(cur_mix[3:2], IN_LEFT_I, IN_RIGHT_I),
                             pick(cur_mix[1:0], IN_LEFT_I, IN_RIGHT_I)});
        if (!RST_I && OUT_VALID_O && OUT_READY_I) begin
            if (exp_q.size() == 0)
                chk("spare pair", 64'h0, 64'h1);
            else
                chk("pair", exp_q.pop_front(), {OUT_LEFT_O, OUT_RIGHT_O});
        end
    end

    task automatic do_reset();
        @(negedge CLK_I);
        RST_I = 1'b1;
        repeat (5) @(negedge CLK_I);
        RST_I = 1'b0;
        exp_q.delete();
        cur_mix = 4'h9;
        chk("mix rst", 4'h9, MIX_CODE_O);
        chk("bridge rst", 1'b0, HBRIDGE_EN_O);
        chk("pcomp rst", 5'h10, PCOMP_O);
        chk("ncomp rst", 5'h00, NCOMP_O);
        chk("mode rst", 4'h1, SW_MODE_O);
        chk("ready rst", 1'b1, IN_READY_O);
        chk("valid rst", 1'b0, OUT_VALID_O);
    endtask

    task automatic load(input logic [63:0] v);
        logic [63:0] k;
        host_word_model_inst.send(v);
        k = host_word_model_inst.last_word;
        cur_mix = k[49:46];
        chk("mix code", k[49:46], MIX_CODE_O);
        chk("bridge", k[50], HBRIDGE_EN_O);
        chk("pcomp", k[55:51], PCOMP_O);
        chk("ncomp", k[60:56], NCOMP_O);
        chk("alp", k[61], AUTO_LOW_POWER_O);
        chk("speed", k[62], SPEED_HIGH_O);
        chk("method", k[63], METHOD_ENH_O);
        chk("mode", 4'h1 << k[63:62], {SW_MODE_O[3], SW_MODE_O[1],
            SW_MODE_O[2], SW_MODE_O[0]});
    endtask

    // mode 0 random, 1 all zero, 2 extreme values first
    task automatic stream(input int n, input int mode);
        int t;
        for (int i = 0; i < n; i++) begin
            @(negedge CLK_I);
            IN_VALID_I = 1'b1;
            IN_LEFT_I  = (mode == 1) ? 24'h0 : 24'($random(seed));
            IN_RIGHT_I = (mode == 1) ? 24'h0 : 24'($random(seed));
            if (mode == 2 && i < 4) {IN_LEFT_I, IN_RIGHT_I} = corner[i];
            // ready is settled at the falling edge; the pair goes next rise
            t = 0;
            while (IN_READY_O !== 1'b1 && t < 300) begin
                @(negedge CLK_I);
                t++;
            end
            if (IN_READY_O !== 1'b1) begin
                chk("ready wait", 64'h0, 64'h1);
                test_done();
            end
        end
        @(negedge CLK_I);
        IN_VALID_I = 1'b0;
    endtask

    task automatic drain();
        int t;
        t = 0;
        while (exp_q.size() != 0) begin
            @(negedge CLK_I);
            t++;
            if (t > 500) begin
                chk("drain wait", 64'h0, 64'h1);
                test_done();
            end
        end
    endtask

    task automatic tick_gap();
        int t;
        t = 0;
        do begin
            @(negedge CLK_I);
            t++;
        end while (PWM_TICK_O !== 1'b1 && t < 300);
        gap = 0;
        do begin
            @(negedge CLK_I);
            gap++;
        end while (PWM_TICK_O !== 1'b1 && gap < 300);
    endtask

    initial begin
        seed = 33;
        bad_count = 0;
        compares = 0;
        RST_I = 1'b1;
        IN_VALID_I = 1'b0;
        IN_LEFT_I = 24'h0;
        IN_RIGHT_I = 24'h0;
        OUT_READY_I = 1'b1;
        hold = 1'b0;
        jitter = 1'b0;
        cur_mix = 4'h9;
        do_reset();
        host_word_model_inst.first_use();
        chk("first mode", 4'h2, SW_MODE_O);
        stream(4, 2);
        drain();
        // every mix code, random remaining fields, stalling receiver
        jitter = 1'b1;
        for (int c = 0; c < 16; c++) begin
            w = {$random(seed), $random(seed)};
            w[49:46] = c[3:0];
            load(w);
            stream(6, (c == 15 || c == 3) ? 2 : 0);
            drain();
        end
        jitter = 1'b0;
        // carrier period for each speed and method pair
        for (int m = 0; m < 4; m++) begin
            load({m[0], m[1], 1'h0, 5'h00, 5'h10, m[0], 4'h9, 46'h0});
            tick_gap();
            chk("tick gap", (m == 0) ? mixout_pkg::DIV_LO :
                (m == 3) ? mixout_pkg::DIV_HI : mixout_pkg::DIV_MID, gap);
        end
        // fill the two entries with the receiver stalled, then drain
        hold = 1'b1;
        @(negedge CLK_I);
        stream(2, 0);
        chk("full ready", 1'b0, IN_READY_O);
        repeat (4) @(negedge CLK_I);
        chk("held valid", 1'b1, OUT_VALID_O);
        hold = 1'b0;
        drain();
        chk("ready again", 1'b1, IN_READY_O);
        // silence only flagged with auto low power on
        load({3'h0, 5'h00, 5'h10, 1'h1, 4'h9, 46'h0});
        stream(2 * SIL_N, 1);
        drain();
        repeat (3) @(negedge CLK_I);
        chk("silent off", 1'b0, SILENT_O);
        load({3'h1, 5'h00, 5'h10, 1'h1, 4'h9, 46'h0});
        stream(SIL_N, 1);
        drain();
        repeat (3) @(negedge CLK_I);
        chk("silent on", 1'b1, SILENT_O);
        stream(1, 0);
        drain();
        repeat (3) @(negedge CLK_I);
        chk("silent clr", 1'b0, SILENT_O);
        // second reset with the bridge on and a non-default mix
        load({3'h0, 5'h00, 5'h10, 1'h1, 4'h6, 46'h0});
        do_reset();
        test_done();
    end
endmodule

`default_nettype wire
